// file: src/fsra_cfg.svh
// constants for the flash security and ram access block
`ifndef FSRA_CFG_SVH
`define FSRA_CFG_SVH
`define FSRA_ADDR_OPTION 16'h1821
`define FSRA_ADDR_CONFIG 16'h1823
`define FSRA_ADDR_PROTECT 16'h1824
`define FSRA_ADDR_KEYBASE 16'h18f0
`define FSRA_ADDR_STATUS 16'h18f8
`define FSRA_ADDR_ERASE 16'h18f9
`define FSRA_KEY_BYTES 8
`define FSRA_KEY_IDX_W 3
`define FSRA_SEC_UNSECURED 2'h2
`define FSRA_OPT_BACKDOOR_KEY_ENABLE_BIT 7
`define FSRA_CFG_KEY_WRITE_ACCESS_BIT 5
`define FSRA_SP_RESET 16'h00ff
`define FSRA_RAM_DEPTH 16
`define FSRA_RAM_AW 4
`define FSRA_BYTE_ZERO 8'h00
`define FSRA_ERASE_MASS 8'h41
`define FSRA_ERASE_BLANK 8'h05
`endif

// file: src/fsra_pkg.sv
// types for the flash security and ram access block
package fsra_pkg;
    typedef struct packed {
        logic [3:0] ram_addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic from_debug;
        logic from_secure;
    } fsra_ram_req_t;
    typedef enum logic [1:0] {
        FSRA_SECURE = 2'b00,
        FSRA_KEY_OPEN = 2'b01,
        FSRA_ERASED = 2'b10,
        FSRA_OPEN = 2'b11
    } fsra_sec_t;
endpackage

// file: src/fsra_top.sv
// flash security, key compare and ram gating
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "fsra_cfg.svh"
module fsra_top
    import fsra_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [7:0] nv_protection_byte_in,
    input wire logic [7:0] nv_option_byte_in,
    input wire logic [63:0] backdoor_compare_key_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic bus_from_debug_in,
    input wire logic bus_from_secure_in,
    input wire logic flash_blank_in,
    input wire fsra_ram_req_t ram_req_in,
    output logic [7:0] rdata_out,
    output logic [7:0] ram_rdata_out,
    output logic ram_blocked_out,
    output logic secure_out,
    output logic [15:0] sp_reset_out
);
    // ************************************
    // working copies and key state
    // ************************************
    logic [7:0] prot_ff, nxt_prot;
    logic [7:0] opt_ff, nxt_opt;
    logic [7:0] cfg_ff, nxt_cfg;
    logic loaded_ff, nxt_loaded;
    logic [7:0] key_ff [`FSRA_KEY_BYTES];
    logic [7:0] nxt_key [`FSRA_KEY_BYTES];
    logic [`FSRA_KEY_BYTES-1:0] keyw_ff, nxt_keyw;
    logic erase_ff, nxt_erase;
    fsra_sec_t sec_ff, nxt_sec;
    logic key_wr_ok;
    logic [63:0] key_flat;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        hit = (a == b);
    endfunction

    // key bytes only from secure user code, never from debug
    assign key_wr_ok = wr_in && bus_from_secure_in && !bus_from_debug_in
        && cfg_ff[`FSRA_CFG_KEY_WRITE_ACCESS_BIT] && opt_ff[`FSRA_OPT_BACKDOOR_KEY_ENABLE_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < `FSRA_KEY_BYTES; gi++) begin : g_key
            assign key_flat[gi*8 +: 8] = key_ff[gi];
        end
    endgenerate

    always_comb begin
        nxt_prot = prot_ff;
        nxt_opt = opt_ff;
        nxt_cfg = cfg_ff;
        nxt_loaded = 1'b1;
        nxt_key = key_ff;
        nxt_keyw = keyw_ff;
        nxt_erase = erase_ff;
        nxt_sec = sec_ff;
        if (!loaded_ff) begin
            // first cycle after reset copies the nonvolatile bytes
            nxt_prot = nv_protection_byte_in;
            nxt_opt = nv_option_byte_in;
            // unsecured only for 1:0
            nxt_sec = (nv_option_byte_in[1:0] == `FSRA_SEC_UNSECURED) ? FSRA_OPEN : FSRA_SECURE;
        end else begin
            if (wr_in && hit(addr_in, `FSRA_ADDR_CONFIG) && !bus_from_debug_in) begin
                nxt_cfg = wdata_in;
                if (!wdata_in[`FSRA_CFG_KEY_WRITE_ACCESS_BIT]) begin
                    nxt_keyw = '0;
                end
            end
            if (wr_in && hit(addr_in, `FSRA_ADDR_PROTECT) && sec_ff != FSRA_SECURE) begin
                nxt_prot = wdata_in;
            end
            // compare once all eight bytes are in, only with key enabled
            if (&keyw_ff) begin
                nxt_keyw = '0;
                if (opt_ff[`FSRA_OPT_BACKDOOR_KEY_ENABLE_BIT] && key_flat == backdoor_compare_key_in
                    && sec_ff == FSRA_SECURE) begin
                    nxt_sec = FSRA_KEY_OPEN;
                end
            end
            // byte written in the compare cycle keeps its written flag
            for (int i = 0; i < `FSRA_KEY_BYTES; i++) begin
                if (key_wr_ok && hit(addr_in, `FSRA_ADDR_KEYBASE + 16'(i))) begin
                    nxt_key[i] = wdata_in;
                    nxt_keyw[i] = 1'b1;
                end
            end
            // mass erase then confirmed blank check lifts security
            if (wr_in && hit(addr_in, `FSRA_ADDR_ERASE)) begin
                if (wdata_in == `FSRA_ERASE_MASS) begin
                    nxt_erase = 1'b1;
                end else if (wdata_in == `FSRA_ERASE_BLANK && erase_ff && flash_blank_in) begin
                    nxt_erase = 1'b0;
                    nxt_sec = FSRA_ERASED;
                end else begin
                    nxt_erase = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prot_ff <= `FSRA_BYTE_ZERO;
            opt_ff <= `FSRA_BYTE_ZERO;
            cfg_ff <= `FSRA_BYTE_ZERO;
            loaded_ff <= 1'b0;
            keyw_ff <= '0;
            erase_ff <= 1'b0;
            sec_ff <= FSRA_SECURE;
            for (int i = 0; i < `FSRA_KEY_BYTES; i++) begin
                key_ff[i] <= `FSRA_BYTE_ZERO;
            end
        end else if (ce_in) begin
            prot_ff <= nxt_prot;
            opt_ff <= nxt_opt;
            cfg_ff <= nxt_cfg;
            loaded_ff <= nxt_loaded;
            keyw_ff <= nxt_keyw;
            erase_ff <= nxt_erase;
            sec_ff <= nxt_sec;
            key_ff <= nxt_key;
        end
    end

    // ************************************
    // register read port
    // ************************************
    logic [7:0] nxt_rdata;
    logic is_secure;
    assign is_secure = (sec_ff == FSRA_SECURE);

    always_comb begin
        nxt_rdata = `FSRA_BYTE_ZERO;
        if (rd_in) begin
            unique case (addr_in)
                `FSRA_ADDR_OPTION: nxt_rdata = opt_ff;
                `FSRA_ADDR_CONFIG: nxt_rdata = cfg_ff;
                `FSRA_ADDR_PROTECT: nxt_rdata = prot_ff;
                `FSRA_ADDR_STATUS: nxt_rdata = {5'h00, erase_ff, sec_ff};
                default: nxt_rdata = `FSRA_BYTE_ZERO;
            endcase
        end
    end

    // ************************************
    // ram with security gate
    // ************************************
    // no reset on the array: contents survive every reset
    logic [7:0] ram_mem [`FSRA_RAM_DEPTH];
    logic blocked;
    logic [7:0] nxt_ram_rdata;
    // debug or non-secure code is shut out while secure
    assign blocked = is_secure && (ram_req_in.from_debug || !ram_req_in.from_secure);

    always_comb begin
        nxt_ram_rdata = `FSRA_BYTE_ZERO;
        if (ram_req_in.rd && !blocked) begin
            nxt_ram_rdata = ram_mem[ram_req_in.ram_addr];
        end
    end

    always_ff @(posedge clk_in) begin
        if (ce_in && ram_req_in.wr && !blocked) begin
            ram_mem[ram_req_in.ram_addr] <= ram_req_in.wdata;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= `FSRA_BYTE_ZERO;
            ram_rdata_out <= `FSRA_BYTE_ZERO;
            ram_blocked_out <= 1'b0;
            secure_out <= 1'b1;
            sp_reset_out <= `FSRA_SP_RESET;
        end else if (ce_in) begin
            rdata_out <= nxt_rdata;
            ram_rdata_out <= nxt_ram_rdata;
            ram_blocked_out <= (ram_req_in.rd || ram_req_in.wr) && blocked;
            secure_out <= (nxt_sec == FSRA_SECURE);
            sp_reset_out <= `FSRA_SP_RESET;
        end
    end

    // ************************************
    // checks
    // ************************************
    property p_load;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && !loaded_ff) |=> (opt_ff == $past(nv_option_byte_in));
    endproperty
    a_load: assert property (p_load) else $error("option copy not loaded");

    property p_nokey;
        @(posedge clk_in) disable iff (rst_in)
        (loaded_ff && !opt_ff[`FSRA_OPT_BACKDOOR_KEY_ENABLE_BIT] && sec_ff == FSRA_SECURE && ce_in
            && !(wr_in && addr_in == `FSRA_ADDR_ERASE)) |=> (sec_ff == FSRA_SECURE);
    endproperty
    a_nokey: assert property (p_nokey) else $error("unlock with key off");

    property p_dbgkey;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && wr_in && bus_from_debug_in && loaded_ff) |=> $stable(key_flat);
    endproperty
    a_dbgkey: assert property (p_dbgkey) else $error("debug loaded key");

    property p_src;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && wr_in && !bus_from_secure_in && loaded_ff) |=> $stable(keyw_ff) || keyw_ff == '0;
    endproperty
    a_src: assert property (p_src) else $error("key from non-secure");

    property p_block;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && is_secure && ram_req_in.rd && ram_req_in.from_debug)
            |=> ram_blocked_out && ram_rdata_out == `FSRA_BYTE_ZERO;
    endproperty
    a_block: assert property (p_block) else $error("secure ram leaked");

    property p_sp;
        @(posedge clk_in) disable iff (rst_in)
        1'b1 |-> sp_reset_out == `FSRA_SP_RESET;
    endproperty
    a_sp: assert property (p_sp) else $error("stack reset value wrong");

    property p_sec;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && !loaded_ff && nv_option_byte_in[1:0] != `FSRA_SEC_UNSECURED) |=> is_secure;
    endproperty
    a_sec: assert property (p_sec) else $error("wrong security decode");

    property p_erase;
        @(posedge clk_in) disable iff (rst_in)
        (sec_ff == FSRA_SECURE ##1 sec_ff == FSRA_ERASED) |-> $past(erase_ff && flash_blank_in);
    endproperty
    a_erase: assert property (p_erase) else $error("erase unlock without blank");

    property p_prot;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && !loaded_ff) |=> (prot_ff == $past(nv_protection_byte_in));
    endproperty
    a_prot: assert property (p_prot) else $error("protection copy not loaded");

    property p_keyopen;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && loaded_ff && (&keyw_ff) && opt_ff[`FSRA_OPT_BACKDOOR_KEY_ENABLE_BIT]
            && sec_ff == FSRA_SECURE && key_flat == backdoor_compare_key_in
            && !(wr_in && addr_in == `FSRA_ADDR_ERASE)) |=> (sec_ff == FSRA_KEY_OPEN);
    endproperty
    a_keyopen: assert property (p_keyopen) else $error("matching key did not unlock");

    property p_keysrc;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && loaded_ff && wr_in && !bus_from_secure_in) |=> $stable(key_flat);
    endproperty
    a_keysrc: assert property (p_keysrc) else $error("key byte from non-secure code");

    property p_unsec;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && !loaded_ff && nv_option_byte_in[1:0] == `FSRA_SEC_UNSECURED) |=> !is_secure;
    endproperty
    a_unsec: assert property (p_unsec) else $error("unsecured pattern not honoured");

    property p_wrblock;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && is_secure && ram_req_in.wr && (ram_req_in.from_debug || !ram_req_in.from_secure))
            |=> ram_blocked_out;
    endproperty
    a_wrblock: assert property (p_wrblock) else $error("secure ram write not blocked");

    property p_rdzero;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && is_secure && ram_req_in.rd && !ram_req_in.from_secure)
            |=> ram_blocked_out && ram_rdata_out == `FSRA_BYTE_ZERO;
    endproperty
    a_rdzero: assert property (p_rdzero) else $error("non-secure code read secure ram");

    property p_open;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && !is_secure && (ram_req_in.rd || ram_req_in.wr)) |=> !ram_blocked_out;
    endproperty
    a_open: assert property (p_open) else $error("ram blocked while unsecured");

    property p_secout;
        @(posedge clk_in) disable iff (rst_in)
        secure_out == is_secure;
    endproperty
    a_secout: assert property (p_secout) else $error("secure flag disagrees with state");

    property p_keyhold;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && sec_ff == FSRA_KEY_OPEN && !(wr_in && addr_in == `FSRA_ADDR_ERASE))
            |=> (sec_ff == FSRA_KEY_OPEN);
    endproperty
    a_keyhold: assert property (p_keyhold) else $error("key unlock lost before reset");
endmodule
`default_nettype wire

// file: test/fsra_cpu_model.sv
// cpu and debug port model that drives the register and ram ports
`timescale 1ns/10ps
`default_nettype none
module fsra_cpu_model
    import fsra_pkg::*;
(
    input wire logic clk_in,
    output logic [15:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    output logic dbg_out,
    output logic sec_out,
    output fsra_ram_req_t ram_out
);
    initial begin
        addr_out = 16'h0000;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        dbg_out = 1'b0;
        sec_out = 1'b1;
        ram_out = '0;
    end
    // one register cycle; src is {debug, secure}; erase requests come in from debug
    task automatic reg_acc(input logic w, input logic [15:0] a, input logic [7:0] d,
            input logic [1:0] src);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        {dbg_out, sec_out} <= src;
        wr_out <= w;
        rd_out <= ~w;
        @(posedge clk_in);
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        // released lines do not keep their last value
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
    task automatic ram_acc(input logic w, input logic [3:0] a, input logic [7:0] d,
            input logic [1:0] src);
        @(posedge clk_in);
        ram_out <= '{a, d, w, ~w, src[1], src[0]};
        @(posedge clk_in);
        ram_out <= '{~a, ~d, 1'b0, 1'b0, src[1], src[0]};
    endtask
endmodule
`default_nettype wire

// file: test/test_fsra_top.sv
// self-checking bench for the flash security and ram access block
`timescale 1ns/10ps
`default_nettype none
`include "fsra_cfg.svh"
module test_fsra_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] nv_opt = 8'h80;
    logic [63:0] key = 64'h0123456789abcdef;
    logic blank = 1'b0;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr, rd, dbg, sec, blocked, secure;
    fsra_pkg::fsra_ram_req_t ram_req;
    logic [7:0] rdata;
    logic [7:0] ram_rdata;
    logic [15:0] sp;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    always #4 clk_in = ~clk_in;
    fsra_cpu_model i_fsra_cpu_model (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd), .dbg_out(dbg), .sec_out(sec), .ram_out(ram_req));
    fsra_top i_fsra_top (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
        .nv_protection_byte_in(8'h5a), .nv_option_byte_in(nv_opt),
        .backdoor_compare_key_in(key), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .bus_from_debug_in(dbg), .bus_from_secure_in(sec),
        .flash_blank_in(blank), .ram_req_in(ram_req), .rdata_out(rdata),
        .ram_rdata_out(ram_rdata), .ram_blocked_out(blocked), .secure_out(secure),
        .sp_reset_out(sp));
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset(input logic [7:0] opt);
        @(posedge clk_in);
        rst_in <= 1'b1;
        nv_opt <= opt;
        repeat (4) @(posedge clk_in);
        #1 chk({15'h0000, secure}, 16'h0001);
        chk(sp, `FSRA_SP_RESET);
        @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        i_fsra_cpu_model.reg_acc(1'b0, a, 8'h00, 2'b01);
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask
    task automatic ram_chk(input logic w, input logic [3:0] a, input logic [7:0] d,
            input logic [1:0] src, input logic [8:0] exp);
        i_fsra_cpu_model.ram_acc(w, a, d, src);
        #1 chk({7'h00, blocked, ram_rdata}, {7'h00, exp});
    endtask
    task automatic send_key(input logic [63:0] k, input logic [1:0] src, input logic exp);
        i_fsra_cpu_model.reg_acc(1'b1, `FSRA_ADDR_CONFIG, 8'h20, src);
        for (int i = 0; i < `FSRA_KEY_BYTES; i++) begin
            i_fsra_cpu_model.reg_acc(1'b1, `FSRA_ADDR_KEYBASE + 16'(i), k[8*i +: 8], src);
        end
        repeat (3) @(posedge clk_in);
        #1 chk({15'h0000, secure}, {15'h0000, exp});
    endtask
    task automatic t_load();
        do_reset(8'h80);
        rd_chk(`FSRA_ADDR_OPTION, 8'h80);
        rd_chk(`FSRA_ADDR_PROTECT, 8'h5a);
    endtask
    task automatic t_ram_gate();
        ram_chk(1'b1, 4'h3, 8'ha5, 2'b01, 9'h000);
        ram_chk(1'b0, 4'h3, 8'h00, 2'b01, 9'h0a5);
        ram_chk(1'b0, 4'h3, 8'h00, 2'b10, 9'h100);
        ram_chk(1'b1, 4'h3, 8'h3c, 2'b00, 9'h100);
        ram_chk(1'b0, 4'h3, 8'h00, 2'b01, 9'h0a5);
    endtask
    task automatic t_key();
        send_key(key, 2'b10, 1'b1);
        rd_chk(`FSRA_ADDR_CONFIG, 8'h00);
        send_key(key, 2'b00, 1'b1);
        send_key(~key, 2'b01, 1'b1);
        send_key(key, 2'b01, 1'b0);
        rd_chk(`FSRA_ADDR_STATUS, {6'h00, fsra_pkg::FSRA_KEY_OPEN});
        ram_chk(1'b0, 4'h3, 8'h00, 2'b10, 9'h0a5);
        do_reset(8'h80);
        #1 chk({15'h0000, secure}, 16'h0001);
        ram_chk(1'b0, 4'h3, 8'h00, 2'b10, 9'h100);
        ram_chk(1'b0, 4'h3, 8'h00, 2'b01, 9'h0a5);
    endtask
    task automatic t_key_off();
        do_reset(8'h00);
        send_key(key, 2'b01, 1'b1);
        rd_chk(`FSRA_ADDR_OPTION, 8'h00);
        i_fsra_cpu_model.reg_acc(1'b1, `FSRA_ADDR_ERASE, `FSRA_ERASE_MASS, 2'b10);
        i_fsra_cpu_model.reg_acc(1'b1, `FSRA_ADDR_ERASE, `FSRA_ERASE_BLANK, 2'b10);
        #1 chk({15'h0000, secure}, 16'h0001);
        @(posedge clk_in);
        blank <= 1'b1;
        i_fsra_cpu_model.reg_acc(1'b1, `FSRA_ADDR_ERASE, `FSRA_ERASE_MASS, 2'b10);
        i_fsra_cpu_model.reg_acc(1'b1, `FSRA_ADDR_ERASE, `FSRA_ERASE_BLANK, 2'b10);
        repeat (2) @(posedge clk_in);
        #1 chk({15'h0000, secure}, 16'h0000);
        rd_chk(`FSRA_ADDR_STATUS, {6'h00, fsra_pkg::FSRA_ERASED});
        @(posedge clk_in);
        blank <= 1'b0;
    endtask
    task automatic t_sec_field();
        for (int i = 0; i < 4; i++) begin
            do_reset({6'h20, 2'(i)});
            #1 chk({15'h0000, secure}, {15'h0000, 2'(i) != 2'b10});
        end
    endtask
    initial begin
        t_load();
        t_ram_gate();
        t_key();
        t_key_off();
        t_sec_field();
        print_verdict();
    end
endmodule
`default_nettype wire
